// [rtl/pllpd_top.sv]
// Phase frequency detector with three-state output and oscillator output stage
//
// How it works
// - Select low full rate, high half rate
// - Stop control halts oscillator and clears its half-rate phase
// - Oscillator output held low while stopped
// - Oscillator and detector inhibited independently
// - Detector disable releases output to high-impedance
// - Disabled detector stops comparing phases
// - Edge compare reference versus feedback, report
module pllpd_top
  import pllpd_pkg::*;
(
  input  wire logic CLOCK,              // 10 MHz system clock
  input  wire logic SYS_RST,            // Synchronous reset, active high
  input  wire logic OSC_SELECT,         // High selects half rate output
  input  wire logic OSC_STOP_CTRL,      // High stops the oscillator
  input  wire logic DETECTOR_DISABLE,   // High disables the detector
  input  wire logic REF_IN,             // Reference input
  input  wire logic FB_IN,              // Feedback counter input
  output logic      OSC_OUTPUT,         // Oscillator output
  output logic      DETECTOR_OUTPUT_O,  // Detector drive level
  output logic      DETECTOR_OUTPUT_OE  // Detector drive enable, high drives
);

  logic [PIN_COUNT-1:0] sync1_r;
  logic [PIN_COUNT-1:0] sync2_r;
  logic [1:0]           edge_prev_r;
  logic                 ref_rise;
  logic                 fb_rise;
  pllpd_pfd_state_t     pfd_state_r;
  pllpd_pfd_state_t     pfd_state_nxt;
  pllpd_pump_t          pump;
  pllpd_drive_t         drive_r;
  pllpd_drive_t         drive_nxt;
  logic                 disable_s;

  // Two-stage synchronisers on every pin input
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sync1_r <= SYNC_RST_VAL;
      sync2_r <= SYNC_RST_VAL;
    end else begin
      sync1_r <= {FB_IN, REF_IN, DETECTOR_DISABLE, OSC_STOP_CTRL, OSC_SELECT};
      sync2_r <= sync1_r;
    end
  end

  assign disable_s = sync2_r[PIN_DISABLE];

  // Oscillator section, independent of the detector
  pllpd_out_div u_out_div (
    .clk      (CLOCK),
    .rst      (SYS_RST),
    .stop     (sync2_r[PIN_STOP]),
    .half_sel (sync2_r[PIN_SELECT]),
    .osc_out  (OSC_OUTPUT)
  );

  // Edge detection on synchronised reference and feedback
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      edge_prev_r <= 2'h0;
    end else begin
      edge_prev_r <= {sync2_r[PIN_FB], sync2_r[PIN_REF]};
    end
  end

  assign ref_rise = sync2_r[PIN_REF] && !edge_prev_r[0];
  assign fb_rise  = sync2_r[PIN_FB] && !edge_prev_r[1];

  // Tri-state detector: a leading edge opens a pump, the lagging edge closes it
  always_comb begin
    pfd_state_nxt = pfd_state_r;
    if (disable_s) begin
      pfd_state_nxt = PFD_IDLE;
    end else begin
      case (pfd_state_r)
        PFD_IDLE: begin
          if (ref_rise && !fb_rise) begin
            pfd_state_nxt = PFD_UP;
          end else if (fb_rise && !ref_rise) begin
            pfd_state_nxt = PFD_DN;
          end
        end
        PFD_UP: begin
          if (fb_rise) begin
            pfd_state_nxt = PFD_IDLE;
          end
        end
        PFD_DN: begin
          if (ref_rise) begin
            pfd_state_nxt = PFD_IDLE;
          end
        end
        default: pfd_state_nxt = PFD_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pfd_state_r <= PFD_IDLE;
    end else begin
      pfd_state_r <= pfd_state_nxt;
    end
  end

  // One process drives the whole pump struct, so each member has one driver
  always_comb begin
    pump.up = (pfd_state_nxt == PFD_UP);
    pump.dn = (pfd_state_nxt == PFD_DN);
  end

  // Pump drive onto the three-state pin
  always_comb begin
    drive_nxt.level = pump.up;
    drive_nxt.oe    = (pump.up || pump.dn) && !disable_s;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      drive_r.level <= PFD_RST_VAL;
      drive_r.oe    <= PFD_RST_VAL;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign DETECTOR_OUTPUT_O  = drive_r.level;
  assign DETECTOR_OUTPUT_OE = drive_r.oe;

endmodule // pllpd_top

// [rtl/pllpd_pkg.sv]
// Shared constants and types for the phase detector and oscillator output block
package pllpd_pkg;

  // Number of flip-flops in each pin synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  // Pin synchroniser bit positions
  localparam int unsigned PIN_SELECT  = 0;
  localparam int unsigned PIN_STOP    = 1;
  localparam int unsigned PIN_DISABLE = 2;
  localparam int unsigned PIN_REF     = 3;
  localparam int unsigned PIN_FB      = 4;
  localparam int unsigned PIN_COUNT   = 5;

  // Output stage divide ratio when the half-rate select is high
  localparam int unsigned HALF_DIVIDE = 2;

  // Reset values
  localparam logic [PIN_COUNT-1:0] SYNC_RST_VAL = 5'h00;
  localparam logic                 OSC_RST_VAL  = 1'h0;
  localparam logic                 PFD_RST_VAL  = 1'h0;

  // Detector pump request state
  typedef struct packed {
    logic up;   // Reference edge leads
    logic dn;   // Feedback edge leads
  } pllpd_pump_t;

  // Detector pin drive: level and enable
  typedef struct packed {
    logic level;
    logic oe;
  } pllpd_drive_t;

  typedef enum logic [2:0] {
    PFD_IDLE = 3'h1,
    PFD_UP   = 3'h2,
    PFD_DN   = 3'h4
  } pllpd_pfd_state_t;

endpackage : pllpd_pkg

// [rtl/pllpd_out_div.sv]
// Oscillator model with selectable divide-by-two output stage and stop control
module pllpd_out_div
  import pllpd_pkg::*;
(
  input  wire logic clk,        // System clock
  input  wire logic rst,        // Synchronous reset, active high
  input  wire logic stop,       // Halt oscillator, output low
  input  wire logic half_sel,   // High selects half rate output
  output logic      osc_out     // Oscillator output, registered
);

  logic       osc_out_r;
  logic       osc_out_nxt;
  logic       half_phase_r;

  // Core runs at full rate; half rate toggles the output on every other step
  always_comb begin
    if (stop) begin
      osc_out_nxt = 1'h0;
    end else if (half_sel && !half_phase_r) begin
      osc_out_nxt = osc_out_r;
    end else begin
      osc_out_nxt = ~osc_out_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || stop) begin
      half_phase_r <= 1'h0;
    end else if (half_sel) begin
      half_phase_r <= ~half_phase_r;
    end else begin
      half_phase_r <= 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_out_r <= OSC_RST_VAL;
    end else begin
      osc_out_r <= osc_out_nxt;
    end
  end

  assign osc_out = osc_out_r;

endmodule // pllpd_out_div

// [dv/pllpd_partner.sv]
// Reference source and feedback counter model
module pllpd_partner (
  input  wire logic clk,   // Clock
  output logic      ref_o, // Reference
  output logic      fb_o   // Counter
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ref_o, fb_o} = 2'h0;
  // Each line rises after its own delay, both drop together; clean source, no recovered clock
  task automatic edges(input int r, input int f);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      if (i == r) ref_o = 1'h1;
      if (i == f) fb_o = 1'h1;
    end
    {ref_o, fb_o} = 2'h0;
  endtask
endmodule // pllpd_partner

// [dv/pllpd_monitor.sv]
// Checker on the top ports
module pllpd_monitor (
  input wire logic CLOCK,             // Clock
  input wire logic SYS_RST,           // Reset
  input wire logic OSC_SELECT,        // Rate
  input wire logic OSC_STOP_CTRL,     // Stop
  input wire logic DETECTOR_DISABLE,  // Off
  input wire logic REF_IN,            // Ref
  input wire logic FB_IN,             // Fb
  input wire logic OSC_OUTPUT,        // Osc
  input wire logic DETECTOR_OUTPUT_O, // Level
  input wire logic DETECTOR_OUTPUT_OE // Drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  stop_low_a: assert property (OSC_STOP_CTRL[*4] |=> !OSC_OUTPUT) else $error("stop");
  full_rate_a: assert property ((!OSC_STOP_CTRL && !OSC_SELECT)[*5] |=> OSC_OUTPUT != $past(OSC_OUTPUT))
    else $error("full");
  half_rate_a: assert property ((!OSC_STOP_CTRL && OSC_SELECT)[*8] |=> OSC_OUTPUT != $past(OSC_OUTPUT, 2))
    else $error("half");
  drive_off_a: assert property (DETECTOR_DISABLE[*4] |=> !DETECTOR_OUTPUT_OE) else $error("oe");
  stay_idle_a: assert property (DETECTOR_DISABLE[*5] ##1 !DETECTOR_DISABLE |-> !DETECTOR_OUTPUT_OE[*3])
    else $error("idle");
  ref_lead_a: assert property (($rose(REF_IN) && !FB_IN && !DETECTOR_OUTPUT_OE && !DETECTOR_DISABLE)
    ##1 !FB_IN[*3] |=> DETECTOR_OUTPUT_O && DETECTOR_OUTPUT_OE) else $error("up");
  fb_lead_a: assert property (($rose(FB_IN) && !REF_IN && !DETECTOR_OUTPUT_OE && !DETECTOR_DISABLE)
    ##1 !REF_IN[*3] |=> !DETECTOR_OUTPUT_O && DETECTOR_OUTPUT_OE) else $error("dn");
  both_seen_a: assert property ($rose(FB_IN) && DETECTOR_OUTPUT_OE |-> ##[1:4] !DETECTOR_OUTPUT_OE)
    else $error("hold");
endmodule // pllpd_monitor
bind pllpd_top pllpd_monitor u_mon (.CLOCK, .SYS_RST, .OSC_SELECT, .OSC_STOP_CTRL, .DETECTOR_DISABLE,
  .REF_IN, .FB_IN, .OSC_OUTPUT, .DETECTOR_OUTPUT_O, .DETECTOR_OUTPUT_OE);

// [dv/pllpd_tb_top.sv]
// Testbench for the detector and oscillator output block
module pllpd_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic sel = 1'h0;
  logic stop = 1'h0;
  logic dis = 1'h0;
  wire  ref_s, fb_s, osc, lvl, oe;
  int   errors = 0;
  int   tests_run = 0;
  int   cyc = 0;
  always #50 clk = ~clk;
  pllpd_partner p (.clk(clk), .ref_o(ref_s), .fb_o(fb_s));
  pllpd_top dut (.CLOCK(clk), .SYS_RST(rst), .OSC_SELECT(sel), .OSC_STOP_CTRL(stop),
    .DETECTOR_DISABLE(dis), .REF_IN(ref_s), .FB_IN(fb_s), .OSC_OUTPUT(osc),
    .DETECTOR_OUTPUT_O(lvl), .DETECTOR_OUTPUT_OE(oe));
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Count output changes over eight cycles once the select has settled
  task automatic rate(input logic s, input logic [3:0] e);
    logic last;
    int n;
    n = 0;
    sel = s;
    repeat (8) @(negedge clk);
    last = osc;
    repeat (8) begin
      @(negedge clk);
      n += int'(osc !== last);
      last = osc;
    end
    chk("toggles", e, 4'(n));
    $display("rate %0d done", s);
  endtask
  task automatic pump(input int r, input int f, input logic eoe, input logic eo);
    fork
      p.edges(r, f);
      begin
        repeat ((r < f ? r : f) + 5) @(negedge clk);
        chk("drive", 4'(eoe), 4'(oe));
        if (eoe) chk("level", 4'(eo), 4'(lvl));
      end
    join
    chk("release", 4'h0, 4'(oe));
    repeat (3) @(negedge clk);
    $display("pump %0d %0d done", r, f);
  endtask
  task automatic t_stop();
    stop = 1'h1;
    repeat (5) @(negedge clk);
    repeat (8) begin
      @(negedge clk);
      chk("osc low", 4'h0, 4'(osc));
    end
    pump(0, 4, 1'h1, 1'h1);
    stop = 1'h0;
    rate(1'h0, 4'h8);
    $display("stop done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    rate(1'h0, 4'h8);
    rate(1'h1, 4'h4);
    dis = 1'h1;
    rate(1'h0, 4'h8);
    pump(0, 4, 1'h0, 1'h0);
    dis = 1'h0;
    repeat (4) @(negedge clk);
    chk("idle", 4'h0, 4'(oe));
    pump(0, 4, 1'h1, 1'h1);
    pump(4, 0, 1'h1, 1'h0);
    pump(2, 2, 1'h0, 1'h0);
    t_stop();
    end_of_test();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      errors++;
      end_of_test();
    end
  end
endmodule // pllpd_tb_top
